// ==== src/pwmcc_pkg.sv ====
// What this block does
// - Bit 13 gates channel interrupt events
// - Bits 12-10 pick the clock scaler
// - Scaler choice accepted only while channel disabled
// - Waveform enable bit 9 reads zero
// - Dual compare inert; compare reloads at zero
// - Method bit 6 always reads asymmetric zero
// - Fix bit 3 forces main to bit 4
// - Pair plus fix forces complement to bit 5
// - Forcing beats polarity; needs both enables
// - Paired complement inverts main while running, dead band allowed
// - Unpaired complement output stays low
// - Polarity bit 1: one high, zero low
// - Polarity change only after disabling write; immediate
// - Polarity resets to default polarity flag
// - Enable change lands on next scaled tick
// - Dead band only when bit 21 set
package pwmcc_pkg;

   // ======================================================
   // Register map
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] ADDR_GLOBAL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h24;
   localparam logic [ADDR_W-1:0] ADDR_COMPARE = 8'h28;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h2C;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h50;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h54;

   // ======================================================
   // Control word field positions
   localparam int B_EN = 0;
   localparam int B_POL = 1;
   localparam int B_PAIR = 2;
   localparam int B_FIX_ON = 3;
   localparam int B_FIX_MAIN = 4;
   localparam int B_FIX_COMP = 5;
   localparam int B_GENERATION_METHOD_SELECT = 6;
   localparam int B_RSVD = 7;
   localparam int B_DUAL_COMPARE_SWITCH = 8;
   localparam int B_WEN = 9;
   localparam int B_DIV_LO = 10;
   localparam int DIV_W = 3;
   localparam int B_IRQ_GATE = 13;
   localparam int B_DEADTIME_INSERT_ENABLE = 21;
   localparam int B_GLOBAL_EN = 0;

   // ======================================================
   // Widths and reset values
   localparam int CNT_W = 16;
   localparam int PRE_W = 8;
   localparam int DB_W = 8;
   localparam int IRQ_W = 2;
   localparam int IRQ_PERIOD = 0;
   localparam int IRQ_COMPARE = 1;
   localparam logic [CNT_W-1:0] PERIOD_RST = 16'h00FF;
   localparam logic [CNT_W-1:0] COMPARE_RST = 16'h0080;

   typedef struct packed {
      logic deadtime_insert_enable;
      logic irq_gate;
      logic [DIV_W-1:0] div_choice;
      logic dual_cmp;
      logic fix_comp;
      logic fix_main;
      logic fix_on;
      logic pair;
      logic output_polarity_select;
      logic en;
   } pwmcc_ctrl_t;

   typedef struct packed {
      pwmcc_ctrl_t ctrl;
      logic global_en;
      logic active_en;
      logic [CNT_W-1:0] period;
      logic [CNT_W-1:0] compare;
      logic [CNT_W-1:0] cmp_active;
      logic [CNT_W-1:0] cnt;
      logic [PRE_W-1:0] pre_cnt;
      logic [1:0][DB_W-1:0] db_cnt;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_mask;
      logic [DATA_W-1:0] rdata;
      logic pwm;
      logic pwm_comp;
   } pwmcc_state_t;

endpackage : pwmcc_pkg

// ==== src/pwmcc_channel.sv ====
`timescale 1ns/1ps
module pwmcc_channel #(
   parameter int divider_count_param = 8,
   parameter logic default_polarity_flag = 1'b1,
   parameter logic dual_compare_capability = 1'b1,
   parameter logic [pwmcc_pkg::DB_W-1:0] DEADBAND_CYCLES = 8'h04
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [pwmcc_pkg::ADDR_W-1:0] i_addr,
   input wire logic [pwmcc_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [pwmcc_pkg::DATA_W-1:0] o_rdata,
   output logic o_pwm,
   output logic o_pwm_comp,
   output logic o_irq
);

   pwmcc_pkg::pwmcc_state_t s;
   pwmcc_pkg::pwmcc_state_t next_s;

   logic wr_ctrl;
   logic run;
   logic tick;
   logic fixing;
   logic [pwmcc_pkg::PRE_W-1:0] tick_mask;
   logic [1:0] raw;
   logic [1:0] act;
   logic [pwmcc_pkg::IRQ_W-1:0] events;
   logic [pwmcc_pkg::IRQ_W-1:0] clr;

   assign wr_ctrl = i_wr && (i_addr == pwmcc_pkg::ADDR_CTRL);
   assign run = s.active_en && s.global_en;
   assign fixing = run && s.ctrl.fix_on;

   // ======================================================
   // Scaled clock ticks
   // Scaler k divides the system clock by two to the k
   always_comb begin
      tick_mask = '0;
      for (int k = 0; k < pwmcc_pkg::PRE_W; k++) begin
         if (k < int'(s.ctrl.div_choice)) begin
            tick_mask[k] = 1'b1;
         end
      end
   end
   assign tick = (s.pre_cnt & tick_mask) == tick_mask;

   // ======================================================
   // Waveform and dead band
   always_comb begin
      raw = 2'b00;
      if (run) begin
         raw[0] = s.cnt < s.cmp_active;
         raw[1] = !raw[0];
      end
      for (int i = 0; i < 2; i++) begin
         // Delay only the rising edge of each active phase
         act[i] = raw[i] && (!s.ctrl.deadtime_insert_enable || s.db_cnt[i] >= DEADBAND_CYCLES);
      end
   end

   always_comb begin
      events = '0;
      if (run && tick && s.ctrl.irq_gate) begin
         events[pwmcc_pkg::IRQ_PERIOD] = s.cnt == s.period;
         events[pwmcc_pkg::IRQ_COMPARE] = s.cnt == s.cmp_active;
      end
      clr = '0;
      if (i_wr && (i_addr == pwmcc_pkg::ADDR_IRQ_STATUS)) begin
         clr = i_wdata[pwmcc_pkg::IRQ_W-1:0];
      end
   end

   // ======================================================
   // Next state
   always_comb begin
      next_s = s;
      next_s.pre_cnt = s.pre_cnt + 1'b1;

      // Register writes
      if (wr_ctrl) begin
         // Lock test uses the stored enable, i.e. the previous write
         if (!s.ctrl.en) begin
            if (divider_count_param > 1 &&
                int'(i_wdata[pwmcc_pkg::B_DIV_LO +: pwmcc_pkg::DIV_W]) < divider_count_param) begin
               next_s.ctrl.div_choice = i_wdata[pwmcc_pkg::B_DIV_LO +: pwmcc_pkg::DIV_W];
            end
            next_s.ctrl.output_polarity_select = i_wdata[pwmcc_pkg::B_POL];
         end
         next_s.ctrl.irq_gate = i_wdata[pwmcc_pkg::B_IRQ_GATE];
         next_s.ctrl.dual_cmp = dual_compare_capability && i_wdata[pwmcc_pkg::B_DUAL_COMPARE_SWITCH];
         next_s.ctrl.fix_comp = i_wdata[pwmcc_pkg::B_FIX_COMP];
         next_s.ctrl.fix_main = i_wdata[pwmcc_pkg::B_FIX_MAIN];
         next_s.ctrl.fix_on = i_wdata[pwmcc_pkg::B_FIX_ON];
         next_s.ctrl.pair = i_wdata[pwmcc_pkg::B_PAIR];
         next_s.ctrl.en = i_wdata[pwmcc_pkg::B_EN];
         next_s.ctrl.deadtime_insert_enable = i_wdata[pwmcc_pkg::B_DEADTIME_INSERT_ENABLE];
      end
      if (i_wr && (i_addr == pwmcc_pkg::ADDR_GLOBAL)) begin
         next_s.global_en = i_wdata[pwmcc_pkg::B_GLOBAL_EN];
      end
      if (i_wr && (i_addr == pwmcc_pkg::ADDR_PERIOD)) begin
         next_s.period = i_wdata[pwmcc_pkg::CNT_W-1:0];
      end
      if (i_wr && (i_addr == pwmcc_pkg::ADDR_COMPARE)) begin
         next_s.compare = i_wdata[pwmcc_pkg::CNT_W-1:0];
      end
      if (i_wr && (i_addr == pwmcc_pkg::ADDR_IRQ_MASK)) begin
         next_s.irq_mask = i_wdata[pwmcc_pkg::IRQ_W-1:0];
      end
      // A new event beats a clear in the same cycle
      next_s.irq_status = (s.irq_status & ~clr) | events;

      // Enable reaches the outputs only on a scaled tick
      if (tick) begin
         next_s.active_en = s.ctrl.en;
      end

      // Counter; asymmetric only, so dual compare changes nothing
      if (!run) begin
         next_s.cnt = '0;
         next_s.cmp_active = s.compare;
      end else if (tick) begin
         if (s.cnt == '0) begin
            next_s.cmp_active = s.compare;
         end
         if (s.cnt >= s.period) begin
            next_s.cnt = '0;
         end else begin
            next_s.cnt = s.cnt + 1'b1;
         end
      end

      for (int i = 0; i < 2; i++) begin
         if (!raw[i]) begin
            next_s.db_cnt[i] = '0;
         end else if (s.db_cnt[i] < DEADBAND_CYCLES) begin
            next_s.db_cnt[i] = s.db_cnt[i] + 1'b1;
         end
      end

      // Outputs: forcing beats polarity
      if (fixing) begin
         next_s.pwm = s.ctrl.fix_main;
      end else begin
         next_s.pwm = s.ctrl.output_polarity_select ? act[0] : !act[0];
      end
      if (!s.ctrl.pair) begin
         next_s.pwm_comp = 1'b0;
      end else if (fixing) begin
         next_s.pwm_comp = s.ctrl.fix_comp;
      end else begin
         next_s.pwm_comp = s.ctrl.output_polarity_select ? act[1] : !act[1];
      end

      // Read data stand one cycle after the strobe; unmapped reads zero
      next_s.rdata = '0;
      if (i_rd) begin
         case (i_addr)
            pwmcc_pkg::ADDR_CTRL: begin
               // Bits 9, 7 and 6 stay zero in this build
               next_s.rdata[pwmcc_pkg::B_EN] = s.ctrl.en;
               next_s.rdata[pwmcc_pkg::B_POL] = s.ctrl.output_polarity_select;
               next_s.rdata[pwmcc_pkg::B_PAIR] = s.ctrl.pair;
               next_s.rdata[pwmcc_pkg::B_FIX_ON] = s.ctrl.fix_on;
               next_s.rdata[pwmcc_pkg::B_FIX_MAIN] = s.ctrl.fix_main;
               next_s.rdata[pwmcc_pkg::B_FIX_COMP] = s.ctrl.fix_comp;
               next_s.rdata[pwmcc_pkg::B_DUAL_COMPARE_SWITCH] = s.ctrl.dual_cmp;
               next_s.rdata[pwmcc_pkg::B_DIV_LO +: pwmcc_pkg::DIV_W] = s.ctrl.div_choice;
               next_s.rdata[pwmcc_pkg::B_IRQ_GATE] = s.ctrl.irq_gate;
               next_s.rdata[pwmcc_pkg::B_DEADTIME_INSERT_ENABLE] = s.ctrl.deadtime_insert_enable;
            end
            pwmcc_pkg::ADDR_GLOBAL: begin
               next_s.rdata[pwmcc_pkg::B_GLOBAL_EN] = s.global_en;
            end
            pwmcc_pkg::ADDR_PERIOD: begin
               next_s.rdata[pwmcc_pkg::CNT_W-1:0] = s.period;
            end
            pwmcc_pkg::ADDR_COMPARE: begin
               next_s.rdata[pwmcc_pkg::CNT_W-1:0] = s.compare;
            end
            pwmcc_pkg::ADDR_IRQ_STATUS: begin
               next_s.rdata[pwmcc_pkg::IRQ_W-1:0] = s.irq_status;
            end
            pwmcc_pkg::ADDR_IRQ_MASK: begin
               next_s.rdata[pwmcc_pkg::IRQ_W-1:0] = s.irq_mask;
            end
            default: begin
               next_s.rdata = '0;
            end
         endcase
      end
   end

   // ======================================================
   // State register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s <= '0;
         s.ctrl.output_polarity_select <= default_polarity_flag;
         s.pwm <= !default_polarity_flag;
         s.period <= pwmcc_pkg::PERIOD_RST;
         s.compare <= pwmcc_pkg::COMPARE_RST;
         s.cmp_active <= pwmcc_pkg::COMPARE_RST;
      end else begin
         s <= next_s;
      end
   end

   assign o_rdata = s.rdata;
   assign o_pwm = s.pwm;
   assign o_pwm_comp = s.pwm_comp;
   assign o_irq = |(s.irq_status & s.irq_mask);

   // ======================================================
   // Checks
   a_irq_gate_off: assert property (@(posedge i_clk) disable iff (i_rst)
      !s.ctrl.irq_gate |=> ((s.irq_status & ~$past(s.irq_status)) == '0))
      else $error("interrupt raised while gate off");

   a_div_locked: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr_ctrl && s.ctrl.en) |=> $stable(s.ctrl.div_choice))
      else $error("scaler changed while enabled");

   // Only the control word owns bits 9 and 6; period data may set them
   a_wave_bit_zero: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_rd && i_addr == pwmcc_pkg::ADDR_CTRL) |=> !o_rdata[pwmcc_pkg::B_WEN])
      else $error("waveform bit read as one");

   a_method_zero: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_rd && i_addr == pwmcc_pkg::ADDR_CTRL) |=> !o_rdata[pwmcc_pkg::B_GENERATION_METHOD_SELECT])
      else $error("method bit read as one");

   a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_rd && i_addr == pwmcc_pkg::ADDR_CTRL) |=> !o_rdata[pwmcc_pkg::B_RSVD])
      else $error("reserved bit read as one");

   a_cmp_reload: assert property (@(posedge i_clk) disable iff (i_rst)
      (run && $changed(s.cmp_active)) |-> ($past(s.cnt) == '0))
      else $error("compare reloaded away from zero");

   a_fix_main: assert property (@(posedge i_clk) disable iff (i_rst)
      fixing |=> (o_pwm == $past(s.ctrl.fix_main)))
      else $error("main output not forced");

   a_fix_comp: assert property (@(posedge i_clk) disable iff (i_rst)
      (fixing && s.ctrl.pair) |=> (o_pwm_comp == $past(s.ctrl.fix_comp)))
      else $error("complement output not forced");

   a_pair_invert: assert property (@(posedge i_clk) disable iff (i_rst)
      (run && s.ctrl.pair && !s.ctrl.fix_on && !s.ctrl.deadtime_insert_enable) |=> (o_pwm_comp != o_pwm))
      else $error("paired outputs not inverse");

   a_pair_off: assert property (@(posedge i_clk) disable iff (i_rst)
      !s.ctrl.pair |=> !o_pwm_comp)
      else $error("unpaired complement not low");

   a_pol_locked: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr_ctrl && s.ctrl.en) |=> $stable(s.ctrl.output_polarity_select))
      else $error("polarity changed while enabled");

   a_enable_wait: assert property (@(posedge i_clk) disable iff (i_rst)
      !tick |=> $stable(s.active_en))
      else $error("enable applied off a scaled tick");

   a_enable_lands: assert property (@(posedge i_clk) disable iff (i_rst)
      tick |=> (s.active_en == $past(s.ctrl.en)))
      else $error("enable not applied on a scaled tick");

   a_pol_accept: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr_ctrl && !s.ctrl.en) |=> (s.ctrl.output_polarity_select == $past(i_wdata[pwmcc_pkg::B_POL])))
      else $error("polarity write lost while disabled");

   // Stopped channel shows the inactive level of the chosen polarity
   a_stop_level: assert property (@(posedge i_clk) disable iff (i_rst)
      !run |=> (o_pwm == !$past(s.ctrl.output_polarity_select)))
      else $error("stopped main output not inactive");

   a_fix_unpaired: assert property (@(posedge i_clk) disable iff (i_rst)
      (fixing && !s.ctrl.pair) |=> !o_pwm_comp)
      else $error("unpaired complement forced high");

   a_dead_hold: assert property (@(posedge i_clk) disable iff (i_rst)
      (s.ctrl.deadtime_insert_enable && s.db_cnt[0] < DEADBAND_CYCLES) |-> !act[0])
      else $error("main active inside dead band");

   a_dead_off: assert property (@(posedge i_clk) disable iff (i_rst)
      !s.ctrl.deadtime_insert_enable |-> (act == raw))
      else $error("dead band added while disabled");

   a_irq_set: assert property (@(posedge i_clk) disable iff (i_rst)
      events[pwmcc_pkg::IRQ_PERIOD] |=> s.irq_status[pwmcc_pkg::IRQ_PERIOD])
      else $error("period event lost");

   a_dual_cap: assert property (@(posedge i_clk) disable iff (i_rst)
      !dual_compare_capability |-> !s.ctrl.dual_cmp)
      else $error("dual compare stored without capability");

   a_rdata_idle: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_rd |=> (o_rdata == '0))
      else $error("read data not zero when idle");

endmodule : pwmcc_channel

// ==== verif/pwm_channel_control_low_bits_tb_top.sv ====
`timescale 1ns/1ps
module pwm_channel_control_low_bits_tb_top;
   localparam int DB = 4;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h00000000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic o_pwm;
   logic o_pwm_comp;
   logic o_irq;
   int miscompares = 0;
   int checks = 0;
   int cyc = 0;
   int cm = 2;
   int p;
   int c;
   logic [31:0] d;

   pwmcc_channel #(.DEADBAND_CYCLES(8'h04)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_pwm(o_pwm), .o_pwm_comp(o_pwm_comp), .o_irq(o_irq));

   always #20 i_clk = ~i_clk;

   // ==========================================
   // Reporting
   task automatic finish_test();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Long enough for all scenarios with margin
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         finish_test();
      end
   end

   // ==========================================
   // Register bus and model
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      v = o_rdata;
   endtask : rd

   // Divider and polarity frozen while the stored enable is set
   function automatic int upd(input int o, input int w);
      int n;
      n = w & 32'h00203D3F;
      if (o & 1) n = (n & ~32'h1C02) | (o & 32'h1C02);
      return n;
   endfunction : upd

   task automatic wc(input int v);
      cm = upd(cm, v);
      wr(8'h2C, v);
      rd(8'h2C, d);
      chk(d, cm);
   endtask : wc

   // Count high cycles over four periods; outputs checked inverse only when inv is set
   task automatic duty(input int pp, input int cc, input int ctl, input int em, input int ec,
                       input bit inv);
      int hm;
      int hc;
      hm = 0;
      hc = 0;
      wr(8'h24, pp);
      wr(8'h28, cc);
      wc(0);
      wc(ctl);
      repeat (2 * (pp + 1) + DB + 4) @(negedge i_clk);
      repeat (4 * (pp + 1)) begin
         @(negedge i_clk);
         hm += o_pwm;
         hc += o_pwm_comp;
         if (inv) chk(o_pwm_comp, !o_pwm);
      end
      chk(hm, em);
      chk(hc, ec);
   endtask : duty

   // ==========================================
   // Scenarios
   initial begin
      void'($urandom(70));
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
      rd(8'h2C, d);
      chk(d, 32'h00000002);
      chk(o_pwm, 1'b0);
      chk(o_pwm_comp, 1'b0);
      rd(8'h10, d);
      chk(d, 32'h00000000);
      wc(32'hFFFFFFFE);
      wc(32'h00000001);
      wc(32'h00001C03);
      wc(32'h00000000);
      wr(8'h00, 32'h00000001);
      duty(3, 2, 32'h7, 8, 8, 1'b1);
      duty(3, 1, 32'h5, 12, 4, 1'b1);
      duty(5, 2, 32'h3, 8, 0, 1'b0);
      duty(15, 8, 32'h200007, 4 * (8 - DB), 4 * (8 - DB), 1'b0);
      for (int i = 0; i < 3; i++) begin
         p = 2 + $urandom % 14;
         c = 1 + $urandom % p;
         duty(p, c, 32'h7, 4 * c, 4 * (p + 1 - c), 1'b1);
      end
      wc(0);
      wc(32'h1F);
      repeat (4) @(negedge i_clk);
      chk({o_pwm, o_pwm_comp}, 2'b10);
      wr(8'h00, 32'h00000000);
      repeat (4) @(negedge i_clk);
      chk({o_pwm, o_pwm_comp}, 2'b00);
      wr(8'h00, 32'h00000001);
      wc(0);
      wr(8'h50, 32'h00000003);
      wr(8'h54, 32'h00000001);
      wc(32'h2001);
      // Random period may reach 15, so wait past one full period
      repeat (20) @(negedge i_clk);
      chk(o_irq, 1'b1);
      wr(8'h54, 32'h00000000);
      @(negedge i_clk);
      chk(o_irq, 1'b0);
      wc(0);
      wr(8'h50, 32'h00000003);
      rd(8'h50, d);
      chk(d, 32'h00000000);
      wr(8'h54, 32'h00000003);
      wc(32'h1);
      repeat (12) @(negedge i_clk);
      rd(8'h50, d);
      chk(d, 32'h00000000);
      chk(o_irq, 1'b0);
      finish_test();
   end
endmodule : pwm_channel_control_low_bits_tb_top
